// ===== hw/tdmal_timing.sv
// timing front end: input framing, output clocks and frame pulses, stream alignment
`timescale 1ns/1ns
`default_nettype none
module tdmal_timing #(
  parameter int FRAME_CYC = tdmal_pkg::FRAME_CYC,
  parameter int FIFO_D = tdmal_pkg::FIFO_DEPTH
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire tdmal_pkg::tdmal_mode_t i_mode,
  input wire logic i_input_clock,
  input wire logic i_input_frame_pulse,
  input wire logic [1:0] i_input_clock_select,
  input wire logic i_input_clock_polarity,
  input wire logic i_input_frame_polarity,
  input wire logic i_input_frame_position,
  input wire logic i_slave_loop_enable,
  input wire logic [5:0] i_output_clock_polarity,
  input wire logic [3:0] i_output_frame_polarity,
  input wire logic [3:0] i_output_frame_position,
  input wire logic [1:0] i_programmable_output3_select,
  input wire logic i_output_clock4_select,
  input wire logic i_sonet_frame_pulse_enable,
  input wire logic [5:0] i_clk_out_en,
  input wire logic [4:0] i_fp_out_en,
  input wire logic [1:0] i_in_rate,
  input wire logic [2:0] i_input_bit_delay_field,
  input wire logic [1:0] i_input_sample_point_field,
  input wire logic i_stream_in,
  input wire logic [1:0] i_out_rate,
  input wire logic [2:0] i_output_bit_advance_field,
  input wire logic [1:0] i_output_fraction_advance_field,
  input wire logic [2:0] i_highz_control_advance_field,
  output logic [5:0] o_output_clocks,
  output logic [5:0] o_output_clocks_oe,
  output logic [4:0] o_output_frame_pulses,
  output logic [4:0] o_output_frame_pulses_oe,
  output logic o_stream_out,
  output logic o_external_highz_control,
  output logic o_in_ready,
  output logic o_in_overrun
);
  import tdmal_pkg::*;

  typedef struct packed {
    logic [2:0] ck_s;
    logic [2:0] fp_s;
    logic [2:0] dt_s;
    logic ck_v;
    logic fp_v;
    logic dt_v;
    logic fp_act;
    logic [13:0] frm;
    logic [5:0][14:0] cacc;
    logic [5:0][13:0] chalf;
    logic [14:0] qacc;
    logic [13:0] iq;
    logic [14:0] oacc;
    logic [13:0] oq;
    logic [7:0] ish;
    logic pv;
    logic [7:0] pdata;
    logic ovr;
    logic [7:0] osh;
    logic ovld;
    logic [5:0] ck_o;
    logic [4:0] fp_o;
    logic sd;
    logic hz;
  } tdmal_state_t;

  localparam tdmal_state_t ST_RST = '{hz: 1'b1, sd: 1'b1, fp_o: 5'h1F, default: '0};

  tdmal_state_t q, d;
  tdmal_fifo_if #(.W(BYTE_W)) fif ();

  tdmal_fifo #(.W(BYTE_W), .D(FIFO_D)) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .f(fif)
  );

  // returns {tick, next accumulator}; fractional rates spread ticks evenly over a frame
  function automatic logic [15:0] nco_step(input logic [14:0] acc, input logic [14:0] step);
    logic [15:0] s;
    s = {1'b0, acc} + {1'b0, step};
    if (s >= 16'(FRAME_CYC)) begin
      nco_step = {1'b1, 15'(s - 16'(FRAME_CYC))};
    end else begin
      nco_step = {1'b0, s[14:0]};
    end
  endfunction

  logic slave, gci_in, ck_new, fp_new, in_act, sel_edge, bound, restart;
  logic itick, otick;
  logic [5:0] valid;
  logic [5:0][14:0] cstep;
  logic [5:0] base;
  logic [5:0][1:0] fidx;
  logic [1:0] inidx;

  assign slave = (i_mode == TDMAL_DIV_SLAVE) || (i_mode == TDMAL_MUL_SLAVE);
  assign gci_in = i_input_frame_position && i_input_frame_polarity;

  // rates of the outputs, steps are half periods per frame
  always_comb begin
    cstep[0] = HS_4M;
    cstep[1] = HS_8M;
    cstep[2] = HS_16M;
    cstep[3] = 15'(HS_4M << i_programmable_output3_select);
    cstep[4] = i_output_clock4_select ? HS_2M : HS_1M5;
    cstep[5] = HS_19M;
    fidx[0] = 2'd0;
    fidx[1] = 2'd1;
    fidx[2] = 2'd2;
    fidx[3] = i_programmable_output3_select;
    fidx[4] = 2'd0;
    fidx[5] = 2'd0;
    base = 6'b10_0000;
    // unused code 11 is treated as the fastest input clock
    unique case (i_input_clock_select)
      CKSEL_8M: inidx = 2'd1;
      CKSEL_4M: inidx = 2'd0;
      default: inidx = 2'd2;
    endcase
    for (int i = 0; i < 4; i++) begin
      valid[i] = !((i_mode == TDMAL_DIV_SLAVE) && (fidx[i] > inidx));
    end
    valid[4] = !(slave && !i_slave_loop_enable);
    valid[5] = !(slave && !i_slave_loop_enable);
  end

  logic [15:0] r;
  logic [15:0] ri;
  logic [15:0] ro;
  logic [13:0] h;
  logic [13:0] last;
  logic act;
  logic [1:0] smp;
  logic [13:0] sq;
  logic [13:0] bd;
  logic [13:0] eq;
  logic [13:0] eh;
  logic [13:0] imask;
  logic [13:0] omask;
  logic [1:0] fq;
  logic [2:0] hzq;
  logic [2:0] b;

  always_comb begin
    d = q;
    r = '0;
    h = '0;
    last = '0;
    act = 1'b0;
    fif.rd_ready = 1'b0;
    // three stage synchronisers; a level counts once stages two and three agree
    d.ck_s = {q.ck_s[1:0], i_input_clock};
    d.fp_s = {q.fp_s[1:0], i_input_frame_pulse};
    d.dt_s = {q.dt_s[1:0], i_stream_in};
    ck_new = (q.ck_s[1] == q.ck_s[2]) ? q.ck_s[2] : q.ck_v;
    fp_new = (q.fp_s[1] == q.fp_s[2]) ? q.fp_s[2] : q.fp_v;
    d.dt_v = (q.dt_s[1] == q.dt_s[2]) ? q.dt_s[2] : q.dt_v;
    d.ck_v = ck_new;
    d.fp_v = fp_new;
    sel_edge = (ck_new != q.ck_v) && (ck_new == i_input_clock_polarity);
    in_act = i_input_frame_polarity ? fp_new : !fp_new;
    // alternate framing takes only the edge where the pulse has just become active
    bound = slave && sel_edge && in_act && (!gci_in || !q.fp_act);
    if (sel_edge) begin
      d.fp_act = in_act;
    end
    restart = bound || (q.frm == 14'(FRAME_CYC - 1));
    d.frm = restart ? '0 : q.frm + 14'd1;

    for (int i = 0; i < 6; i++) begin
      r = nco_step(q.cacc[i], cstep[i]);
      d.cacc[i] = restart ? '0 : r[14:0];
      d.chalf[i] = restart ? '0 : q.chalf[i] + 14'(r[15]);
      // invalid clocks are parked low rather than toggling at a wrong rate
      d.ck_o[i] = valid[i] && (d.chalf[i][0] ^ base[i] ^ i_output_clock_polarity[i]);
    end
    for (int i = 0; i < 4; i++) begin
      h = d.chalf[i];
      last = cstep[i][13:0] - 14'd1;
      // one clock period wide: straddles the boundary, or follows it when positioned
      act = i_output_frame_position[i] ? (h <= 14'd1) : (h == 14'd0 || h == last);
      if (valid[i]) begin
        d.fp_o[i] = i_output_frame_polarity[i] ? act : !act;
      end else begin
        d.fp_o[i] = !i_output_frame_polarity[i];
      end
    end
    h = d.chalf[5];
    last = HS_19M[13:0] - 14'd1;
    act = (h == 14'd0) || (h == last);
    d.fp_o[4] = !(i_sonet_frame_pulse_enable && valid[5] && act);

    // input stream: quarter bit counter, sample point, whole bit delay
    ri = nco_step(q.qacc, 15'(QSTEP_2M << i_in_rate));
    itick = ri[15];
    d.qacc = restart ? '0 : ri[14:0];
    d.iq = restart ? '0 : q.iq + 14'(itick);
    imask = 14'((QSTEP_2M << i_in_rate) - 15'd1);
    if (i_in_rate == RATE_16M) begin
      smp = (i_input_sample_point_field == 2'b11) ? 2'b11 : 2'b01;
    end else begin
      smp = i_input_sample_point_field;
    end
    sq = (q.iq - {12'h000, smp}) & imask;
    bd = (sq >> 2) - {11'h000, i_input_bit_delay_field};
    d.pv = 1'b0;
    if (itick && sq[1:0] == 2'b00) begin
      d.ish = {q.ish[6:0], q.dt_v};
      if (bd[2:0] == 3'd7) begin
        d.pv = 1'b1;
        d.pdata = {q.ish[6:0], q.dt_v};
      end
    end
    // a full fifo drops the byte and reports it; the sampler cannot pause the line
    d.ovr = q.pv && !fif.wr_ready;

    // output stream: advanced position drives bit and byte timing
    ro = nco_step(q.oacc, 15'(QSTEP_2M << i_out_rate));
    otick = ro[15];
    d.oacc = restart ? '0 : ro[14:0];
    d.oq = restart ? '0 : q.oq + 14'(otick);
    omask = 14'((QSTEP_2M << i_out_rate) - 15'd1);
    if (i_out_rate == RATE_16M) begin
      fq = {i_output_fraction_advance_field[1], 1'b0};
      if (i_highz_control_advance_field >= 3'd4) begin
        hzq = 3'd4;
      end else if (i_highz_control_advance_field >= 3'd2) begin
        hzq = 3'd2;
      end else begin
        hzq = 3'd0;
      end
    end else begin
      fq = i_output_fraction_advance_field;
      hzq = (i_highz_control_advance_field > 3'd4) ? 3'd4 : i_highz_control_advance_field;
    end
    eq = (q.oq + 14'd1 + {9'h000, i_output_bit_advance_field, 2'b00} + {12'h000, fq})
      & omask;
    eh = (eq + {11'h000, hzq}) & omask;
    b = eq[4:2];
    if (otick && eq[1:0] == 2'b00) begin
      if (b == 3'd0) begin
        fif.rd_ready = 1'b1;
        d.osh = fif.rd_data;
        d.ovld = fif.rd_valid;
        d.sd = fif.rd_valid ? fif.rd_data[7] : 1'b1;
      end else begin
        d.sd = q.ovld ? q.osh[~b] : 1'b1;
      end
    end
    // high means the external buffer floats; decided per byte at the advanced point
    if (otick && eh[4:0] == 5'd0) begin
      d.hz = !fif.rd_valid;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      q <= ST_RST;
    end else begin
      q <= d;
    end
  end

  assign fif.wr_valid = q.pv;
  assign fif.wr_data = q.pdata;
  assign o_in_ready = fif.wr_ready;
  assign o_in_overrun = q.ovr;
  assign o_output_clocks = q.ck_o;
  assign o_output_frame_pulses = q.fp_o;
  assign o_output_clocks_oe = i_clk_out_en;
  assign o_output_frame_pulses_oe = i_fp_out_en;
  assign o_stream_out = q.sd;
  assign o_external_highz_control = q.hz;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);

  sequence s_wrap;
    !slave && (q.frm == 14'(FRAME_CYC - 1));
  endsequence
  sequence s_new_frame;
    q.frm == '0 ##1 q.frm == 14'h0001;
  endsequence
  property p_frame_wrap;
    s_wrap |=> s_new_frame;
  endproperty
  a_frame_wrap: assert property (p_frame_wrap) else $error("frame counter did not wrap");

  property p_div_limit;
    (i_mode == TDMAL_DIV_SLAVE && i_input_clock_select == CKSEL_16M
      && i_programmable_output3_select == 2'h3) [*2] |=> !o_output_clocks[3];
  endproperty
  a_div_limit: assert property (p_div_limit) else $error("clock above input clock toggled");

  property p_loop_gate;
    (slave && !i_slave_loop_enable) [*2] |=> !o_output_clocks[4] && !o_output_clocks[5];
  endproperty
  a_loop_gate: assert property (p_loop_gate) else $error("clocks 4 or 5 ran without loop");

  property p_clk_phase;
    restart && !i_output_clock_polarity[0] && !i_output_clock_polarity[5] && valid[0] && valid[5]
      |=> !o_output_clocks[0] && o_output_clocks[5];
  endproperty
  a_clk_phase: assert property (p_clk_phase) else $error("clock phase wrong at boundary");

  property p_st_pulse;
    restart && !i_output_frame_position[0] && !i_output_frame_polarity[0] && valid[0]
      |=> !o_output_frame_pulses[0];
  endproperty
  a_st_pulse: assert property (p_st_pulse) else $error("default pulse not low at boundary");

  property p_gci_pulse;
    restart && i_output_frame_position[1] && i_output_frame_polarity[1] && valid[1]
      |=> o_output_frame_pulses[1] [*4];
  endproperty
  a_gci_pulse: assert property (p_gci_pulse) else $error("alternate pulse not high after boundary");

  property p_sonet_idle;
    !i_sonet_frame_pulse_enable |=> o_output_frame_pulses[4];
  endproperty
  a_sonet_idle: assert property (p_sonet_idle) else $error("aligned pulse active while disabled");

  property p_data_tick;
    $changed(o_stream_out) |-> $past(otick);
  endproperty
  a_data_tick: assert property (p_data_tick) else $error("stream bit changed off its tick");
endmodule // tdmal_timing
`default_nettype wire

// ===== common/tdmal_pkg.sv
// shared constants and types for the tdm stream timing alignment block
package tdmal_pkg;
  localparam int CLK_NS = 8;
  localparam int FRAME_NS = 125000;
  localparam int FRAME_CYC = FRAME_NS / CLK_NS;
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 16;
  // nco steps: half periods (clocks) or quarter bits (streams) per frame
  localparam logic [14:0] QSTEP_2M = 15'h0400;
  localparam logic [14:0] HS_4M = 15'h0400;
  localparam logic [14:0] HS_8M = 15'h0800;
  localparam logic [14:0] HS_16M = 15'h1000;
  localparam logic [14:0] HS_1M5 = 15'h0182;
  localparam logic [14:0] HS_2M = 15'h0200;
  localparam logic [14:0] HS_19M = 15'h12FC;
  localparam logic [1:0] CKSEL_16M = 2'h0;
  localparam logic [1:0] CKSEL_8M = 2'h1;
  localparam logic [1:0] CKSEL_4M = 2'h2;
  localparam logic [1:0] RATE_16M = 2'h3;
  typedef enum logic [1:0] {
    TDMAL_MASTER = 2'b00,
    TDMAL_DIV_SLAVE = 2'b01,
    TDMAL_MUL_SLAVE = 2'b10
  } tdmal_mode_t;
endpackage

// ===== common/tdmal_fifo_if.sv
// byte handshake between the stream sampler, the fifo and the serializer
`timescale 1ns/1ns
`default_nettype none
interface tdmal_fifo_if #(parameter int W = 8);
  logic wr_valid;
  logic wr_ready;
  logic [W-1:0] wr_data;
  logic rd_valid;
  logic rd_ready;
  logic [W-1:0] rd_data;
  modport fifo(input wr_valid, wr_data, rd_ready, output wr_ready, rd_valid, rd_data);
  modport user(output wr_valid, wr_data, rd_ready, input wr_ready, rd_valid, rd_data);
endinterface
`default_nettype wire

// ===== hw/tdmal_fifo.sv
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module tdmal_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  tdmal_fifo_if.fifo f
);
  import tdmal_pkg::*;
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } tdmal_fptr_t;
  tdmal_fptr_t q, d;
  logic [W-1:0] mem [D];
  logic full, empty, do_wr, do_rd;
  // extra pointer bit tells full from empty without a counter
  assign full = (q.wp[AW] != q.rp[AW]) && (q.wp[AW-1:0] == q.rp[AW-1:0]);
  assign empty = (q.wp == q.rp);
  assign f.wr_ready = !full;
  assign f.rd_valid = !empty;
  assign f.rd_data = mem[q.rp[AW-1:0]];
  assign do_wr = f.wr_valid && !full;
  assign do_rd = f.rd_ready && !empty;
  always_comb begin
    d = q;
    if (do_wr) begin
      d.wp = q.wp + 1'b1;
    end
    if (do_rd) begin
      d.rp = q.rp + 1'b1;
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (do_wr) begin
      mem[q.wp[AW-1:0]] <= f.wr_data;
    end
  end
endmodule // tdmal_fifo
`default_nettype wire

// ===== verification/tdmal_peer.sv
// model of a peer tdm device: input clock, input frame pulse and serial data
`timescale 1ns/1ns
`default_nettype none
module tdmal_peer #(
  parameter int HALF_NS = 31,
  parameter int CYC_PER_FRAME = 2048,
  parameter logic [7:0] PATTERN = 8'h5A
) (
  output logic o_input_clock,
  output logic o_input_frame_pulse,
  output logic o_stream_out
);
  int cnt;
  // a tdm clock runs free, so the model never stops it between frames
  initial begin
    o_input_clock = 1'b1;
    o_input_frame_pulse = 1'b1;
    o_stream_out = 1'b1;
    forever begin
      #HALF_NS o_input_clock = ~o_input_clock;
    end
  end
  // pulse is one clock wide and straddles the falling edge that starts the frame
  always @(posedge o_input_clock) begin
    cnt <= (cnt == CYC_PER_FRAME - 1) ? 0 : cnt + 1;
    o_input_frame_pulse <= (cnt != CYC_PER_FRAME - 1);
    o_stream_out <= PATTERN[7 - ((cnt + 1) % 8)];
  end
endmodule // tdmal_peer
`default_nettype wire

// ===== verification/test_tdmal_timing.sv
// testbench for the tdm timing front end
`timescale 1ns/1ns
`default_nettype none
module test_tdmal_timing;
  import tdmal_pkg::*;
  localparam int F = FRAME_CYC;
  typedef struct {
    tdmal_mode_t mode;
    logic [1:0] sel3;
    logic ck4, sonet;
    logic [5:0] cpol, cen;
    logic [3:0] fpol, fpos;
    logic [4:0] fen;
    int tog[6];
    int act[5];
  } tdmal_row_t;
  logic i_ref_clk, i_srst, ick, ifp, sin, i_cpol, i_fpol, i_fpos, i_loop, i_ck4, i_sonet;
  tdmal_mode_t i_mode;
  logic [1:0] i_csel, i_sel3, i_irate, i_orate, i_smp, i_frac;
  logic [5:0] i_cp, i_cen, o_ck, o_ckoe, pc;
  logic [3:0] i_fp, i_fps;
  logic [4:0] i_fen, o_fpo, o_fpoe, pf;
  logic [2:0] i_dly, i_adv, i_hz;
  logic o_so, o_hz, o_rdy, o_ovr, so_p;
  int error_cnt, checks_done, n, hz_lo, so_tg;
  tdmal_row_t rows[5];

  tdmal_peer peer (.o_input_clock(ick), .o_input_frame_pulse(ifp), .o_stream_out(sin));

  tdmal_timing #(.FRAME_CYC(F), .FIFO_D(16)) dut (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_mode(i_mode),
    .i_input_clock(ick), .i_input_frame_pulse(ifp), .i_input_clock_select(i_csel),
    .i_input_clock_polarity(i_cpol), .i_input_frame_polarity(i_fpol),
    .i_input_frame_position(i_fpos), .i_slave_loop_enable(i_loop),
    .i_output_clock_polarity(i_cp), .i_output_frame_polarity(i_fp),
    .i_output_frame_position(i_fps), .i_programmable_output3_select(i_sel3),
    .i_output_clock4_select(i_ck4), .i_sonet_frame_pulse_enable(i_sonet),
    .i_clk_out_en(i_cen), .i_fp_out_en(i_fen), .i_in_rate(i_irate),
    .i_input_bit_delay_field(i_dly), .i_input_sample_point_field(i_smp),
    .i_stream_in(sin), .i_out_rate(i_orate), .i_output_bit_advance_field(i_adv),
    .i_output_fraction_advance_field(i_frac), .i_highz_control_advance_field(i_hz),
    .o_output_clocks(o_ck), .o_output_clocks_oe(o_ckoe), .o_output_frame_pulses(o_fpo),
    .o_output_frame_pulses_oe(o_fpoe), .o_stream_out(o_so),
    .o_external_highz_control(o_hz), .o_in_ready(o_rdy), .o_in_overrun(o_ovr)
  );

  initial begin
    i_ref_clk = 1'b0;
    forever #4 i_ref_clk = ~i_ref_clk;
  end

  task automatic stop_test();
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge i_ref_clk);
    error_cnt++;
    $display("BAD t=%0t watchdog expired", $time);
    stop_test();
  end

  task automatic tick(input int k);
    repeat (k) @(posedge i_ref_clk);
    #1;
  endtask

  task automatic chk_n(input int got, input int exp);
    if (exp >= 0) begin
      checks_done++;
      if (got != exp) begin
        error_cnt++;
        $display("BAD t=%0t count %0d expected %0d", $time, got, exp);
      end
    end
  endtask

  task automatic chk_b(input logic [5:0] got, input logic [5:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_reset();
    chk_b(o_ck, 6'h00);
    chk_b({1'b0, o_fpo}, 6'h1F);
    chk_b({o_so, o_hz, o_ovr}, 6'h06);
  endtask

  task automatic apply(input tdmal_row_t r);
    i_mode = r.mode;
    i_sel3 = r.sel3;
    i_ck4 = r.ck4;
    i_sonet = r.sonet;
    i_cp = r.cpol;
    i_cen = r.cen;
    i_fp = r.fpol;
    i_fps = r.fpos;
    i_fen = r.fen;
  endtask

  // next row lands on the restart cycle, so the whole following frame runs on it
  task automatic measure(input int k, input int len);
    tdmal_row_t r;
    int tog[6];
    int act[5];
    logic [4:0] al;
    r = rows[k];
    al = {1'b0, r.fpol};
    tog = '{default: 0};
    act = '{default: 0};
    if (r.mode != TDMAL_MASTER) begin
      tick(8);
      pc = o_ck ^ i_cp;
      pf = o_fpo;
    end else begin
      chk_b({pc[0], o_ck[0], o_fpo[0]}, 6'h04);
      chk_b({o_ck[5], o_ck[2:1]}, {3'b000, ~r.cpol[5], r.cpol[2:1]});
    end
    chk_b(o_ckoe, r.cen);
    chk_b({1'b0, o_fpoe}, {1'b0, r.fen});
    for (int c = 0; c < len; c++) begin
      // polarity is folded out, so the boundary counts as one toggle whatever the rows
      for (int i = 0; i < 6; i++) tog[i] += int'((pc[i] ^ o_ck[i] ^ i_cp[i]) !== 1'b0);
      // pulse ends, not starts: a start may sit on the boundary sample of either row
      for (int i = 0; i < 5; i++)
        act[i] += int'(c > 0 && pf[i] === al[i] && o_fpo[i] !== al[i]);
      pc = o_ck ^ i_cp;
      pf = o_fpo;
      if (c == len - 1 && k < 4) apply(rows[k + 1]);
      tick(1);
    end
    foreach (tog[i]) chk_n(tog[i], r.tog[i]);
    foreach (act[i]) chk_n(act[i], r.act[i]);
  endtask

  initial begin
    rows[0] = '{TDMAL_MASTER, 2'h0, 1'b0, 1'b1, 6'h00, 6'h3F, 4'h0, 4'h0, 5'h1F,
      '{1024, 2048, 4096, 1024, 386, 4860}, '{1, 1, 1, 1, 1}};
    rows[1] = '{TDMAL_MASTER, 2'h1, 1'b1, 1'b0, 6'h06, 6'h15, 4'h4, 4'h4, 5'h0A,
      '{1024, 2048, 4096, 2048, 512, 4860}, '{1, 1, 1, 1, 0}};
    rows[2] = '{TDMAL_MASTER, 2'h2, 1'b0, 1'b1, 6'h20, 6'h2A, 4'h8, 4'h0, 5'h15,
      '{1024, 2048, 4096, 4096, 386, 4860}, '{1, 1, 1, 1, 1}};
    rows[3] = '{TDMAL_MASTER, 2'h3, 1'b1, 1'b1, 6'h1E, 6'h00, 4'hA, 4'hA, 5'h00,
      '{1024, 2048, 4096, 8192, 512, 4860}, '{1, 1, 1, 1, 1}};
    rows[4] = '{TDMAL_DIV_SLAVE, 2'h3, 1'b0, 1'b1, 6'h00, 6'h3F, 4'h0, 4'h0, 5'h1F,
      '{-1, -1, -1, 0, 0, 0}, '{-1, -1, -1, 0, 0}};
    error_cnt = 0;
    checks_done = 0;
    i_srst = 1'b1;
    i_csel = 2'h0;
    i_cpol = 1'b0;
    i_fpol = 1'b0;
    i_fpos = 1'b0;
    i_loop = 1'b0;
    i_irate = 2'h0;
    i_orate = 2'h0;
    i_smp = 2'h2;
    i_frac = 2'h0;
    i_dly = 3'h0;
    i_adv = 3'h0;
    i_hz = 3'h0;
    apply(rows[0]);
    tick(4);
    chk_reset();
    i_srst = 1'b0;
    pc = o_ck;
    pf = o_fpo;
    n = 0;
    while (n < 2 * F && !(pc[0] && !o_ck[0] && !o_fpo[0])) begin
      pc = o_ck;
      pf = o_fpo;
      tick(1);
      n++;
    end
    chk_n(int'(n < 2 * F), 1);
    for (int k = 0; k < 4; k++) measure(k, F);
    measure(4, 2000);
    // fast input into a slow output fills the fifo until a byte is dropped
    apply(rows[0]);
    i_loop = 1'b1;
    i_irate = 2'h3;
    i_dly = 3'h3;
    i_smp = 2'h1;
    i_adv = 3'h5;
    i_frac = 2'h1;
    i_hz = 3'h2;
    n = 0;
    while (n < 8000 && o_ovr !== 1'b1) begin
      tick(1);
      n++;
    end
    chk_n(int'(n < 8000), 1);
    i_irate = 2'h0;
    i_orate = 2'h3;
    n = 0;
    while (n < 4000 && o_rdy !== 1'b1) begin
      tick(1);
      n++;
    end
    chk_n(int'(n < 4000), 1);
    n = 0;
    hz_lo = 0;
    so_tg = 0;
    so_p = o_so;
    // slow input into a fast output: bytes pass, the buffer is driven and data moves
    repeat (2000) begin
      tick(1);
      n += int'(o_ovr !== 1'b0);
      hz_lo += int'(o_hz === 1'b0);
      so_tg += int'(o_so !== so_p);
      so_p = o_so;
    end
    chk_n(n, 0);
    chk_n(int'(hz_lo > 0), 1);
    chk_n(int'(so_tg > 0), 1);
    i_srst = 1'b1;
    tick(2);
    chk_reset();
    i_srst = 1'b0;
    tick(1);
    // first edge after release is the frame start: clock 5 high, pulses active
    chk_b(o_ck, 6'h20);
    chk_b({1'b0, o_fpo}, 6'h00);
    stop_test();
  end
endmodule // test_tdmal_timing
`default_nettype wire
